// file: rtl/fbct_pkg.sv
// Purpose: Constants and types for the frame buffer column strobe timing block.
// Assumes: sys_clk at 10 MHz; one access cycle is a whole number of sys_clk periods.
// Notes:   Strobe phases are counted from the first sys_clk period of an access cycle.
package fbct_pkg;

    // ----------------------------------------------------------------
    // Clock and cycle geometry
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int ACCESS_CYCLES  = 8;
    localparam int PHASE_W        = 3;
    localparam int SYNC_STAGES    = 2;
    localparam int MID_PHASE      = ACCESS_CYCLES / 2;

    // ----------------------------------------------------------------
    // Memory timing figures
    // ----------------------------------------------------------------
    localparam int RAS_DELAY_NS      = 120;
    localparam int ROW_ADDR_HOLD_NS  = 20;
    localparam int WR_DATA_VALID_NS  = 70;
    localparam int WR_BUFFER_NS      = 20;
    localparam int COL_ADDR_HOLD_NS  = 25;
    localparam int CAS_WR_LOW_NS     = 75;
    localparam int RD_CAS_LEAD_NS    = 125;
    localparam int RD_DATA_HOLD_NS   = 10;

    // ----------------------------------------------------------------
    // Derived phases, in sys_clk periods from the cycle start
    // ----------------------------------------------------------------
    localparam int RAS_MIN_PH   = (RAS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAS_PH       = (RAS_MIN_PH > SYNC_STAGES) ? RAS_MIN_PH : SYNC_STAGES + 1;
    localparam int COL_PH       = RAS_PH + (ROW_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAS_RD_PH    = COL_PH + 1;
    localparam int CAS_WR_PH    = MID_PHASE
                                + (WR_DATA_VALID_NS + WR_BUFFER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAS_RD_LATEST = (ACCESS_CYCLES * CLK_PERIOD_NS - RD_CAS_LEAD_NS) / CLK_PERIOD_NS;
    localparam int CAS_WR_LOW_CYC = (CAS_WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COL_HOLD_CYC  = (COL_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [PHASE_W-1:0] LAST_PHASE = PHASE_W'(ACCESS_CYCLES - 1);

    // ----------------------------------------------------------------
    // Synchroniser bit positions
    // ----------------------------------------------------------------
    localparam int SY_W      = 6;
    localparam int SY_BANK0  = 0;
    localparam int SY_BANK1  = 1;
    localparam int SY_RDSTAT = 2;
    localparam int SY_HSYNCN = 3;
    localparam int SY_VALID  = 4;
    localparam int SY_COMMON = 5;

    // ----------------------------------------------------------------
    // Types and reset values
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        FBCT_IDLE = 4'h1,
        FBCT_ROW  = 4'h2,
        FBCT_COL  = 4'h4,
        FBCT_CAS  = 4'h8
    } fbct_seq_t;

    typedef struct packed {
        logic [PHASE_W-1:0] phase;
        logic [SY_W-1:0]    sync1;
        logic [SY_W-1:0]    sync2;
        fbct_seq_t          seq;
        logic               isRead;
        logic               isRefresh;
        logic               useCommon;
        logic               rasN;
        logic               casN;
        logic               rowSel;
        logic [3:0]         weN;
        logic               rdMuxEn;
        logic               ctrlClk;
    } fbct_state_t;

    localparam logic [3:0] WE_NONE = 4'hf;

    localparam fbct_state_t ST_RESET = '{
        phase: '0, sync1: '0, sync2: '0, seq: FBCT_IDLE, isRead: 1'b1,
        isRefresh: 1'b0, useCommon: 1'b0, rasN: 1'b1, casN: 1'b1,
        rowSel: 1'b1, weN: 4'hf, rdMuxEn: 1'b0, ctrlClk: 1'b0
    };

endpackage : fbct_pkg

// file: rtl/fbct_tap_shift.sv
// Purpose: Shift register whose stages mark the phases of an access cycle.
// Assumes: shiftIn pulses for one cycle in the last phase of each access.
// Notes:   Resolution is one sys_clk period; a finer grid needs more stages.
`timescale 1ns/100ps
module fbct_tap_shift #(
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             shiftIn,
    output logic [DEPTH-1:0]      taps
);

    typedef struct packed {
        logic [DEPTH-1:0] stages;
    } fbct_tap_t;

    fbct_tap_t st_r;
    fbct_tap_t st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.stages = {st_r.stages[DEPTH-2:0], shiftIn};
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign taps = st_r.stages;

endmodule : fbct_tap_shift

// file: rtl/fbct_cas_timing.sv
// Purpose: Row/column strobe sequencer for the frame buffer DRAM banks.
// Assumes: Controller pins are asynchronous to sys_clk and pass two flip-flops.
// Notes:   The controller clock is made here, so every access cycle is aligned to phase 0.
`timescale 1ns/100ps
module fbct_cas_timing (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       memoryReadStatus,
    input  wire logic       hsyncN,
    input  wire logic       accessValid,
    input  wire logic [1:0] bankSelect,
    input  wire logic       commonTiming,
    output logic            controllerClock,
    output logic            rasN,
    output logic            casN,
    output logic            rowSel,
    output logic [3:0]      writeEnableN,
    output logic            readMuxEnable
);

    fbct_pkg::fbct_state_t st_r;
    fbct_pkg::fbct_state_t st_nxt;
    logic [fbct_pkg::ACCESS_CYCLES-1:0] taps;
    logic                               lastPhase;

    // ----------------------------------------------------------------
    // Phase taps
    // ----------------------------------------------------------------
    assign lastPhase = (st_r.phase == fbct_pkg::LAST_PHASE);

    fbct_tap_shift #(
        .DEPTH (fbct_pkg::ACCESS_CYCLES)
    ) u_taps (
        .sys_clk (sys_clk),
        .rst     (rst),
        .shiftIn (lastPhase),
        .taps    (taps)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        logic casTap;
        casTap = 1'b0;
        st_nxt = st_r;
        st_nxt.sync1 = {commonTiming, accessValid, hsyncN, memoryReadStatus, bankSelect};
        st_nxt.sync2 = st_r.sync1;
        // Counter restarts at every cycle start; it also shapes the controller clock.
        st_nxt.phase = lastPhase ? '0 : st_r.phase + 3'h1;
        st_nxt.ctrlClk = st_nxt.phase[1];
        if (st_r.isRead && !st_r.useCommon) begin
            casTap = taps[fbct_pkg::CAS_RD_PH-1];
        end else begin
            casTap = taps[fbct_pkg::CAS_WR_PH-1];
        end
        // Next state is chosen from the latched state alone, as in a feedback sequencer.
        case (st_r.seq)
            fbct_pkg::FBCT_IDLE: begin
                if (taps[fbct_pkg::RAS_PH-1] && st_r.sync2[fbct_pkg::SY_VALID]) begin
                    st_nxt.seq       = fbct_pkg::FBCT_ROW;
                    st_nxt.rasN      = 1'b0;
                    st_nxt.isRead    = st_r.sync2[fbct_pkg::SY_RDSTAT];
                    st_nxt.isRefresh = !st_r.sync2[fbct_pkg::SY_HSYNCN];
                    st_nxt.useCommon = st_r.sync2[fbct_pkg::SY_COMMON];
                    if (!st_r.sync2[fbct_pkg::SY_RDSTAT] && st_r.sync2[fbct_pkg::SY_HSYNCN]) begin
                        st_nxt.weN = ~(4'h1 << st_r.sync2[fbct_pkg::SY_BANK1:fbct_pkg::SY_BANK0]);
                    end
                end
            end
            fbct_pkg::FBCT_ROW: begin
                // A refresh cycle is row-only: the column phase is never entered.
                if (taps[fbct_pkg::COL_PH-1] && !st_r.isRefresh) begin
                    st_nxt.seq    = fbct_pkg::FBCT_COL;
                    st_nxt.rowSel = 1'b0;
                end
            end
            fbct_pkg::FBCT_COL: begin
                if (casTap) begin
                    st_nxt.seq     = fbct_pkg::FBCT_CAS;
                    st_nxt.casN    = 1'b0;
                    st_nxt.rdMuxEn = st_r.isRead;
                end
            end
            fbct_pkg::FBCT_CAS: begin
                st_nxt.seq = fbct_pkg::FBCT_CAS;
            end
            default: begin
                st_nxt.seq = fbct_pkg::FBCT_IDLE;
            end
        endcase
        // Strobes end one period after the closing edge, which covers the read data hold.
        if (taps[0]) begin
            st_nxt.seq     = fbct_pkg::FBCT_IDLE;
            st_nxt.rasN    = 1'b1;
            st_nxt.casN    = 1'b1;
            st_nxt.rowSel  = 1'b1;
            st_nxt.rdMuxEn = 1'b0;
            st_nxt.weN     = fbct_pkg::WE_NONE;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= fbct_pkg::ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign controllerClock = st_r.ctrlClk;
    assign rasN            = st_r.rasN;
    assign casN            = st_r.casN;
    assign rowSel          = st_r.rowSel;
    assign writeEnableN    = st_r.weN;
    assign readMuxEnable   = st_r.rdMuxEn;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    casInhibit_a: assert property (!casN |-> !st_r.isRefresh)
        else $error("column strobe low in refresh cycle");
    writeCas_a: assert property ($fell(casN) && !st_r.isRead |-> $past(st_r.phase) == fbct_pkg::CAS_WR_PH - 1)
        else $error("write column strobe at wrong phase");
    readCas_a: assert property ($fell(casN) && st_r.isRead |-> st_r.phase <= fbct_pkg::CAS_RD_LATEST)
        else $error("read column strobe too late");
    rasFall_a: assert property ($fell(rasN) |-> st_r.phase == fbct_pkg::RAS_PH)
        else $error("row strobe at wrong phase");
    colSelect_a: assert property ($fell(rowSel) |-> !rasN && $past(!rasN))
        else $error("column select before row hold");
    writeLow_a: assert property ($fell(casN) && !st_r.isRead |-> (!casN)[*2])
        else $error("write column strobe too short");
    colHold_a: assert property ($fell(casN) |=> !rowSel)
        else $error("column address dropped early");
    muxEnable_a: assert property (readMuxEnable |-> !casN && st_r.isRead)
        else $error("read mux enable outside read strobe");
    idleGap_a: assert property (st_r.phase == 3'h1 |-> rasN && casN)
        else $error("strobe low between cycles");
    weStable_a: assert property ($fell(casN) && !st_r.isRead |-> $stable(writeEnableN) && writeEnableN != 4'hf)
        else $error("write enable not ready at column strobe");
    phaseWrap_a: assert property (lastPhase |=> st_r.phase == 3'h0 ##1 st_r.phase == 3'h1)
        else $error("phase counter did not restart");
    commonCas_a: assert property ($fell(casN) && st_r.useCommon |-> $past(st_r.phase) == fbct_pkg::CAS_WR_PH - 1)
        else $error("common strobe timing not used");

    readCycle_c: cover property ($fell(casN) && st_r.isRead);
    writeCycle_c: cover property ($fell(casN) && !st_r.isRead);
    refreshCycle_c: cover property ($fell(rasN) ##1 st_r.isRefresh);

endmodule : fbct_cas_timing

// file: test/fbct_dram_model.sv
// Purpose: Behavioural frame buffer DRAM array seen from its strobe pins.
// Assumes: Strobes are registered on sys_clk, so sampling at the rising edge is safe.
// Notes:   Counts column strobe falls as writes or reads and latches any protocol fault.
`timescale 1ns/100ps
module fbct_dram_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       rasN,
    input  wire logic       casN,
    input  wire logic       rowSel,
    input  wire logic [3:0] writeEnableN,
    output logic [7:0]      writeCount,
    output logic [7:0]      readCount,
    output logic            protoErr
);
    logic       casPrev;
    logic [3:0] wePrev;

    // ----------------------------------------------------------------
    // Strobe monitor
    // ----------------------------------------------------------------
    // A real array silently corrupts data on these faults, so the model flags them instead.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            casPrev    <= 1'b1;
            wePrev     <= 4'hf;
            writeCount <= 8'h00;
            readCount  <= 8'h00;
            protoErr   <= 1'b0;
        end else begin
            casPrev <= casN;
            wePrev  <= writeEnableN;
            if (casPrev && !casN) begin
                if (rasN || rowSel) protoErr <= 1'b1;
                if (writeEnableN != 4'hf) writeCount <= writeCount + 8'h01;
                else readCount <= readCount + 8'h01;
            end
            if (rasN && !casN) protoErr <= 1'b1;
            if ($countones(~writeEnableN) > 1) protoErr <= 1'b1;
            if (!casN && !casPrev && writeEnableN != wePrev) protoErr <= 1'b1;
        end
    end
endmodule : fbct_dram_model

// file: test/fbct_cas_timing_bench.sv
// Purpose: Self-checking bench for the column strobe sequencer with a DRAM array model.
// Assumes: Bench phase counter mirrors the sequencer's eight-phase access cycle.
// Notes:   Inputs change at the falling edge in phase 7, ahead of the next cycle.
`timescale 1ns/100ps
module fbct_cas_timing_bench;
    logic       sys_clk, rst, memoryReadStatus, hsyncN, accessValid, commonTiming;
    logic [1:0] bankSelect, prevBk;
    logic       controllerClock, rasN, casN, rowSel, readMuxEnable, protoErr;
    logic [3:0] writeEnableN;
    logic [7:0] writeCount, readCount;
    logic [2:0] ph;
    logic       prevV, prevRd, prevHs;
    int         failures, tests_run, cycles;

    fbct_cas_timing i_fbct_cas_timing (.sys_clk(sys_clk), .rst(rst), .memoryReadStatus(memoryReadStatus),
        .hsyncN(hsyncN), .accessValid(accessValid), .bankSelect(bankSelect), .commonTiming(commonTiming),
        .controllerClock(controllerClock), .rasN(rasN), .casN(casN), .rowSel(rowSel),
        .writeEnableN(writeEnableN), .readMuxEnable(readMuxEnable));
    fbct_dram_model i_fbct_dram_model (.sys_clk(sys_clk), .rst(rst), .rasN(rasN), .casN(casN),
        .rowSel(rowSel), .writeEnableN(writeEnableN), .writeCount(writeCount), .readCount(readCount),
        .protoErr(protoErr));

    // ----------------------------------------------------------------
    // Clock, phase mirror and hang guard
    // ----------------------------------------------------------------
    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) ph <= 3'h0;
        else ph <= ph + 3'h1;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Packs {controllerClock, rasN, casN, rowSel, writeEnableN, readMuxEnable}; p = 8 is next phase 0.
    function automatic logic [8:0] expect_out(logic v, logic rd, logic hs, logic [1:0] bk, int p);
        logic       act;
        logic [2:0] pp;
        act = v && hs;
        pp  = p[2:0];
        return {pp[1], !(v && p >= 3), !(act && p >= 5), !(act && p >= 4),
                (act && !rd && p >= 3) ? ~(4'h1 << bk) : 4'hf, act && rd && p >= 5};
    endfunction : expect_out

    task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic run_cycle(input logic v, input logic rd, input logic hs, input logic [1:0] bk, input logic cm);
        logic [8:0] exp;
        while (ph !== 3'h7) @(negedge sys_clk);
        accessValid      = v;
        memoryReadStatus = rd;
        hsyncN           = hs;
        bankSelect       = bk;
        commonTiming     = cm;
        for (int p = 0; p < 8; p++) begin
            @(negedge sys_clk);
            if (p == 0) exp = expect_out(prevV, prevRd, prevHs, prevBk, 8);
            else if (p == 1) exp = expect_out(1'b0, 1'b1, 1'b1, 2'h0, 1);
            else exp = expect_out(v, rd, hs, bk, p);
            check({controllerClock, rasN, casN, rowSel, writeEnableN, readMuxEnable}, exp, "strobes");
        end
        prevV  = v;
        prevRd = rd;
        prevHs = hs;
        prevBk = bk;
    endtask : run_cycle

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_read_write;
        logic [7:0] r0, w0;
        r0 = readCount;
        w0 = writeCount;
        run_cycle(1'b1, 1'b1, 1'b1, 2'h1, 1'b0);
        for (int b = 0; b < 4; b++) run_cycle(1'b1, 1'b0, 1'b1, b[1:0], 1'b0);
        check({1'b0, readCount}, {1'b0, r0 + 8'h01}, "read count");
        check({1'b0, writeCount}, {1'b0, w0 + 8'h04}, "write count");
        $display("test read_write done");
    endtask : test_read_write

    task automatic test_refresh_dummy;
        logic [7:0] r0, w0;
        r0 = readCount;
        w0 = writeCount;
        run_cycle(1'b1, 1'b1, 1'b0, 2'h0, 1'b0);
        run_cycle(1'b1, 1'b0, 1'b0, 2'h2, 1'b0);
        run_cycle(1'b0, 1'b0, 1'b1, 2'h3, 1'b0);
        run_cycle(1'b0, 1'b1, 1'b0, 2'h1, 1'b0);
        check({1'b0, readCount}, {1'b0, r0}, "refresh reads");
        check({1'b0, writeCount}, {1'b0, w0}, "refresh writes");
        $display("test refresh_dummy done");
    endtask : test_refresh_dummy

    task automatic test_common;
        logic [7:0] r0, w0;
        r0 = readCount;
        w0 = writeCount;
        run_cycle(1'b1, 1'b0, 1'b1, 2'h3, 1'b1);
        run_cycle(1'b1, 1'b1, 1'b1, 2'h0, 1'b1);
        check({1'b0, readCount}, {1'b0, r0 + 8'h01}, "common read");
        check({1'b0, writeCount}, {1'b0, w0 + 8'h01}, "common write");
        $display("test common done");
    endtask : test_common

    task automatic test_reset_mid;
        run_cycle(1'b1, 1'b0, 1'b1, 2'h2, 1'b0);
        // The array model clears its fault flag on reset, so earlier faults are judged here first.
        check({8'h00, protoErr}, 9'h000, "array protocol before reset");
        // Reset lands in phase 7 with every strobe active and the controller clock high.
        accessValid = 1'b0;
        rst = 1'b1;
        #1;
        check({controllerClock, rasN, casN, rowSel, writeEnableN, readMuxEnable}, 9'h0fe, "reset");
        repeat (2) @(negedge sys_clk);
        rst    = 1'b0;
        prevV  = 1'b0;
        run_cycle(1'b1, 1'b0, 1'b1, 2'h0, 1'b0);
        run_cycle(1'b0, 1'b1, 1'b1, 2'h0, 1'b0);
        check({8'h00, protoErr}, 9'h000, "array protocol");
        $display("test reset_mid done");
    endtask : test_reset_mid

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    initial begin
        rst = 1'b1;
        memoryReadStatus = 1'b1;
        hsyncN = 1'b1;
        accessValid = 1'b0;
        bankSelect = 2'h0;
        commonTiming = 1'b0;
        prevV = 1'b0;
        prevRd = 1'b1;
        prevHs = 1'b1;
        prevBk = 2'h0;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        test_read_write();
        test_refresh_dummy();
        test_common();
        test_reset_mid();
        stop_test();
    end
endmodule : fbct_cas_timing_bench
